// ---- verification/sdbcs_ctl_model.sv ----
`timescale 1ns/10ps
module sdbcs_ctl_model (
   input  wire logic aclk,
   output logic      chip_select_n,
   output logic      row_strobe_n,
   output logic      column_strobe_n,
   output logic      write_enable_n,
   output logic      bank_select,
   output logic      bank_select_hi,
   output logic      auto_precharge_bit,
   output logic      clock_enable
);
   sdbcs_pkg::sdbcs_pins_s p;
   int                     seed = 79415;
   assign {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = p;
   initial begin
      p = 4'hF;
      {clock_enable, bank_select_hi, bank_select, auto_precharge_bit} = 4'h8;
   end
   task automatic cmd(input logic [3:0] c, logic [1:0] b, logic a);
      @(posedge aclk);
      p <= c;
      {clock_enable, bank_select_hi, bank_select} <= {~&{a, b}, b};
      auto_precharge_bit <= a;
      @(posedge aclk);
      // Deselected noise hides stale strobes
      p <= {1'b1, 3'($random(seed))};
      {clock_enable, bank_select_hi, bank_select} <= {1'b1, 2'($random(seed))};
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
endmodule

// ---- verification/sdbcs_properties.sv ----
`timescale 1ns/10ps
module sdbcs_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        chip_select_n,
   input wire logic        row_strobe_n,
   input wire logic        column_strobe_n,
   input wire logic        write_enable_n,
   input wire logic        bank_select,
   input wire logic        bank_select_hi,
   input wire logic        auto_precharge_bit,
   input wire logic        clock_enable,
   input wire logic [15:0] bank_state,
   input wire logic [2:0]  device_state,
   input wire logic        illegal_command
);
   logic      ck_q;
   wire [3:0] c  = {chip_select_n, row_strobe_n, column_strobe_n,
                    write_enable_n};
   wire [3:0] b0 = bank_state[3:0];
   wire       go = ck_q & clock_enable & (device_state == 3'h0);
   wire       s0 = go & ({bank_select_hi, bank_select} == 2'h0);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) ck_q <= aresetn & clock_enable;
   property p_act; s0 && c == 4'h3 && b0 == 4'h0 |=> b0 == 4'h1;
   endproperty
   a_act: assert property (p_act) else $error("activate");
   property p_activate_to_access_time; b0 == 4'h1 && $past(b0) == 4'h0 |->
      b0 == 4'h1 [*3] ##1 b0 == 4'h2; endproperty
   a_activate_to_access_time: assert property (p_activate_to_access_time) else $error("open time");
   property p_pidle; s0 && c == 4'h2 && !auto_precharge_bit && b0 == 4'h0
      |=> b0 == 4'h0 && !$rose(illegal_command); endproperty
   a_pidle: assert property (p_pidle) else $error("idle close");
   property p_pre; go && c == 4'h2 && (auto_precharge_bit || s0) &&
      b0 inside {4'h2, 4'h3, 4'h4} |=> b0 == 4'h7; endproperty
   a_pre: assert property (p_pre) else $error("close");
   property p_trp; b0 == 4'h7 && $past(b0) != 4'h7 |->
      b0 == 4'h7 [*3] ##1 b0 == 4'h0; endproperty
   a_trp: assert property (p_trp) else $error("close time");
   property p_rd; s0 && c == 4'h5 && b0 == 4'h2 |=>
      b0 == ($past(auto_precharge_bit) ? 4'h5 : 4'h3); endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_intr; go && c == 4'h5 && bank_state[7:0] == 8'h25 &&
      {bank_select_hi, bank_select} == 2'h1 |=> b0 == 4'h7; endproperty
   a_intr: assert property (p_intr) else $error("interrupt");
   property p_ref; go && c == 4'h1 && bank_state == 16'h0 |=>
      device_state == 3'h1 [*8] ##2 device_state == 3'h0; endproperty
   a_ref: assert property (p_ref) else $error("refresh");
   c_intr: cover property (b0 == 4'h5 ##1 b0 == 4'h7);
   c_pall: cover property (device_state == 3'h3);
   c_ref: cover property (device_state == 3'h1);
endmodule

bind sdbcs_top sdbcs_checker u_sdbcs_checker (.*);

// ---- verification/sdbcs_top_tb.sv ----
`timescale 1ns/10ps
module sdbcs_top_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, illegal_command;
   logic        chip_select_n, row_strobe_n, column_strobe_n, write_enable_n;
   logic        bank_select, bank_select_hi, auto_precharge_bit, clock_enable;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] bank_state;
   logic [2:0]  device_state;
   logic [33:0] exp_q[$];
   int          fails, n_checks, cyc;
   sdbcs_ctl_model u_m (.*);
   sdbcs_top u_sdbcs_top (.*);
   task automatic chk(input logic [33:0] g, e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic st(input logic [15:0] e);
      #1 chk(34'(bank_state), 34'(e));
   endtask
   task automatic wr(input logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      wstrb <= 4'($random(u_m.seed)) | 4'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, logic [33:0] e);
      @(posedge aclk);
      exp_q.push_back(e);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
      if (bvalid && bready) chk(34'(bresp), 34'h0);
      if (cyc == 3000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      u_m.idle(2);
      u_m.cmd(4'h3, 2'h3, 1'b1);
      u_m.cmd(4'h2, 2'h0, 1'b0);
      st(16'h0000);
      u_m.cmd(4'h3, 2'h0, 1'b0);
      u_m.idle(3);
      u_m.cmd(4'h5, 2'h0, 1'b0);
      st(16'h0003);
      u_m.cmd(4'h2, 2'h0, 1'b0);
      st(16'h0007);
      u_m.idle(4);
      u_m.cmd(4'h3, 2'h0, 1'b0);
      u_m.cmd(4'h3, 2'h1, 1'b0);
      u_m.idle(3);
      for (int i = 0; i < 2; i++) begin
         u_m.cmd(4'h4 + 4'(i), 2'h0, i[0]);
         st(16'h0024 + 16'(i));
      end
      u_m.cmd(4'h5, 2'h1, 1'b0);
      st(16'h0037);
      u_m.cmd(4'h6, 2'h0, 1'b0);
      st(16'h0027);
      u_m.cmd(4'h2, 2'h0, 1'b1);
      st(16'h0070);
      u_m.idle(4);
      u_m.cmd(4'h1, 2'h0, 1'b0);
      u_m.idle(10);
      u_m.cmd(4'h0, 2'h0, 1'b0);
      u_m.idle(3);
      rd(8'h0C, 34'h0_0050_0000);
      u_m.cmd(4'h5, 2'h2, 1'b0);
      rd(8'h10, 34'h1);
      wr(8'h10, 32'h1);
      rd(8'h10, 34'h0);
      rd(8'h20, 34'h2_0000_0000);
      final_report();
   end
endmodule

// ---- verilog/sdbcs_consts.svh ----
`ifndef SDBCS_CONSTS_SVH
`define SDBCS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SDBCS_OFS_CTRL      8'h00
`define SDBCS_OFS_TIMING0   8'h04
`define SDBCS_OFS_TIMING1   8'h08
`define SDBCS_OFS_STATUS    8'h0C
`define SDBCS_OFS_ERROR     8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDBCS_CTRL_EN_BIT   0
`define SDBCS_T0_TRP_LSB    0
`define SDBCS_T0_ACTIVATE_TO_ACCESS_TIME_LSB   8
`define SDBCS_T0_MODE_LOAD_TIME_LSB   16
`define SDBCS_T0_BLEN_LSB   24
`define SDBCS_T1_REFRESH_CYCLE_TIME_LSB   0
`define SDBCS_T1_SELF_REFRESH_EXIT_TIME_LSB   16
`define SDBCS_ST_BANKS_LSB  0
`define SDBCS_ST_DEV_LSB    16
`define SDBCS_ST_LAST_LSB   20
`define SDBCS_ST_CKEP_BIT   22
`define SDBCS_ERR_ILL_BIT   0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SDBCS_CTRL_RESET    1'b1
`define SDBCS_CLK_NS        8
`define SDBCS_TRP_NS        20
`define SDBCS_ACTIVATE_TO_ACCESS_TIME_NS       20
`define SDBCS_REFRESH_CYCLE_TIME_NS       70
`define SDBCS_MODE_LOAD_TIME_NS       16
`define SDBCS_SELF_REFRESH_EXIT_TIME_NS       80
`define SDBCS_BLEN_RESET    4
`define SDBCS_CYC(ns)       (((ns) + `SDBCS_CLK_NS - 1) / `SDBCS_CLK_NS)
`define SDBCS_RESP_OKAY     2'h0
`define SDBCS_RESP_SLVERR   2'h2

`endif

// ---- verilog/sdbcs_pkg.sv ----
package sdbcs_pkg;

   typedef enum logic [3:0] {
      BANK_IDLE        = 4'h0,
      BANK_ACTIVATING  = 4'h1,
      BANK_ACTIVE      = 4'h2,
      BANK_READ        = 4'h3,
      BANK_WRITE       = 4'h4,
      BANK_READ_AP     = 4'h5,
      BANK_WRITE_AP    = 4'h6,
      BANK_PRECHARGING = 4'h7
   } sdbcs_bank_e;

   typedef enum logic [2:0] {
      DEV_NORMAL  = 3'h0,
      DEV_REFRESH = 3'h1,
      DEV_MODE    = 3'h2,
      DEV_PRE_ALL = 3'h3,
      DEV_SELF    = 3'h4,
      DEV_SR_EXIT = 3'h5
   } sdbcs_dev_e;

   typedef enum logic [3:0] {
      CMD_INHIBIT = 4'h0,
      CMD_NOP     = 4'h1,
      CMD_ACT     = 4'h2,
      CMD_READ    = 4'h3,
      CMD_WRITE   = 4'h4,
      CMD_PRE     = 4'h5,
      CMD_BST     = 4'h6,
      CMD_REF     = 4'h7,
      CMD_LMR     = 4'h8
   } sdbcs_cmd_e;

   typedef struct packed {
      logic chip_select_n;
      logic row_strobe_n;
      logic column_strobe_n;
      logic write_enable_n;
   } sdbcs_pins_s;

endpackage

// ---- verilog/sdbcs_top.sv ----
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "sdbcs_consts.svh"
// How it works
// [RULE_01] Chip select high registers nothing; running operations carry on.
// [RULE_02] Select low with all strobes high is a no-op; operations continue.
// [RULE_03] Activate to an idle bank opens a row in the selected bank.
// [RULE_04] Controller issues refresh or mode load only with all banks idle.
// [RULE_05] Precharge to an idle bank changes nothing, acting as a no-op.
// [RULE_06] Row-active bank accepts read and write, starting a burst.
// [RULE_07] Precharge closes the open row of one bank or all banks.
// [RULE_08] Precharge during a plain read burst cuts it and starts precharge.
// [RULE_09] Precharge during a plain write burst cuts it and starts precharge.
// [RULE_10] Burst terminate ends the latest read or write, whatever its bank.
// [RULE_11] Decoding needs clock enable high twice and self-refresh exit time.
// [RULE_12] Idle after precharge time; active after activate-to-access time.
// [RULE_13] Controller sends nothing to a bank that is busy changing state.
// [RULE_14] Auto-precharge burst keeps bank busy until precharge time passes.
// [RULE_15] Controller sends only inhibit or no-op during device-wide busy.
// [RULE_16] Busy for refresh cycle time or mode load time, then all idle.
// [RULE_17] Controller makes sure every bank may precharge before precharge-all.
// [RULE_18] An idle bank places no limit on commands to other banks.
// [RULE_19] Other banks take activate, read, write, precharge meanwhile.
// [RULE_20] A burst to another bank interrupts the running burst.
// [RULE_21] Read and write transitions hold with or without auto precharge.
// [RULE_22] Controller never sends a state and command pair not tabulated.
// [RULE_23] Auto precharge bit on read or write closes the row after burst.
// [RULE_24] Auto precharge bit on precharge selects all banks.
// [RULE_25] Interrupted auto-precharge burst starts its precharge by itself.
// [RULE_26] Controller masks bytes one clock before a write interrupting reads.
// [RULE_27] Controller keeps per-bank state and counters from timing values.
module sdbcs_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // Command pins
   input  wire logic                chip_select_n,
   input  wire logic                row_strobe_n,
   input  wire logic                column_strobe_n,
   input  wire logic                write_enable_n,
   input  wire logic                bank_select,
   input  wire logic                bank_select_hi,
   input  wire logic                auto_precharge_bit,
   input  wire logic                clock_enable,
   // State view
   output logic [15:0]              bank_state,
   output logic [2:0]               device_state,
   output logic                     illegal_command,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready
);

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   sdbcs_pkg::sdbcs_pins_s pins;
   sdbcs_pkg::sdbcs_cmd_e  cmd;
   logic [1:0]             bank_w;
   logic                   cke_prev_q;
   logic                   ctrl_en_q;
   sdbcs_pkg::sdbcs_dev_e  dev_q;
   logic                   decode_ok;
   logic                   exec_cmd;

   assign pins   = '{chip_select_n, row_strobe_n, column_strobe_n,
                     write_enable_n};
   assign bank_w = {bank_select_hi, bank_select};

   always_comb begin
      if (pins.chip_select_n) begin
         cmd = sdbcs_pkg::CMD_INHIBIT;                           // RULE_01
      end else begin
         unique case ({pins.row_strobe_n, pins.column_strobe_n,
                       pins.write_enable_n})
            3'b111: cmd = sdbcs_pkg::CMD_NOP;                    // RULE_02
            3'b011: cmd = sdbcs_pkg::CMD_ACT;
            3'b101: cmd = sdbcs_pkg::CMD_READ;
            3'b100: cmd = sdbcs_pkg::CMD_WRITE;
            3'b010: cmd = sdbcs_pkg::CMD_PRE;
            3'b110: cmd = sdbcs_pkg::CMD_BST;
            3'b001: cmd = sdbcs_pkg::CMD_REF;
            3'b000: cmd = sdbcs_pkg::CMD_LMR;
         endcase
      end
   end

   assign exec_cmd  = (cmd != sdbcs_pkg::CMD_INHIBIT) &&
                      (cmd != sdbcs_pkg::CMD_NOP);
   // Two high samples of clock enable, control enable set and no device-wide operation
   assign decode_ok = cke_prev_q && clock_enable && ctrl_en_q &&
                      (dev_q == sdbcs_pkg::DEV_NORMAL);          // RULE_11

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= clock_enable;
      end
   end

   // ----------------------------------------------------------------
   // Timing registers
   // ----------------------------------------------------------------
   logic [31:0] timing0_q;
   logic [31:0] timing1_q;
   logic [7:0]  t_rp;
   logic [7:0]  t_rcd;
   logic [7:0]  t_mrd;
   logic [7:0]  t_blen;
   logic [15:0] t_rfc;
   logic [15:0] t_xsr;

   assign t_rp   = timing0_q[`SDBCS_T0_TRP_LSB  +: 8];
   assign t_rcd  = timing0_q[`SDBCS_T0_ACTIVATE_TO_ACCESS_TIME_LSB +: 8];
   assign t_mrd  = timing0_q[`SDBCS_T0_MODE_LOAD_TIME_LSB +: 8];
   assign t_blen = timing0_q[`SDBCS_T0_BLEN_LSB +: 8];
   assign t_rfc  = timing1_q[`SDBCS_T1_REFRESH_CYCLE_TIME_LSB +: 16];
   assign t_xsr  = timing1_q[`SDBCS_T1_SELF_REFRESH_EXIT_TIME_LSB +: 16];

   // ----------------------------------------------------------------
   // Per-bank state
   // ----------------------------------------------------------------
   logic [3:0] st_w [4];
   logic [3:0] all_idle;
   logic [1:0] last_bank_q;
   logic       pre_all;
   logic       rw_cmd;

   assign pre_all = decode_ok && (cmd == sdbcs_pkg::CMD_PRE) &&
                    auto_precharge_bit;                          // RULE_24
   assign rw_cmd  = decode_ok && ((cmd == sdbcs_pkg::CMD_READ) ||
                                  (cmd == sdbcs_pkg::CMD_WRITE));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_bank_q <= 2'h0;
      end else if (rw_cmd) begin
         last_bank_q <= bank_w;                                  // RULE_10
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_bank
      sdbcs_pkg::sdbcs_bank_e st_q;
      logic [7:0]             cnt_q;
      logic                   sel;
      logic                   pre_me;
      logic                   bst_me;
      logic                   other_rw;
      logic                   done;

      assign sel      = decode_ok && (bank_w == 2'(i));
      assign pre_me   = (sel && (cmd == sdbcs_pkg::CMD_PRE)) || pre_all;
      assign bst_me   = decode_ok && (cmd == sdbcs_pkg::CMD_BST) &&
                        (last_bank_q == 2'(i));
      assign other_rw = rw_cmd && (bank_w != 2'(i));
      assign done     = (cnt_q <= 8'h01);
      assign st_w[i]  = st_q;
      assign all_idle[i] = (st_q == sdbcs_pkg::BANK_IDLE);

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            st_q  <= sdbcs_pkg::BANK_IDLE;
            cnt_q <= 8'h00;
         end else begin
            if (cnt_q != 8'h00) begin
               cnt_q <= cnt_q - 8'h01;
            end
            unique case (st_q)
               sdbcs_pkg::BANK_IDLE: begin
                  // Precharge here falls through as a no-op      RULE_05
                  if (sel && (cmd == sdbcs_pkg::CMD_ACT)) begin
                     st_q  <= sdbcs_pkg::BANK_ACTIVATING;        // RULE_03
                     cnt_q <= t_rcd;
                  end
               end
               sdbcs_pkg::BANK_ACTIVATING: begin
                  if (done) begin
                     st_q <= sdbcs_pkg::BANK_ACTIVE;             // RULE_12
                  end
               end
               sdbcs_pkg::BANK_ACTIVE, sdbcs_pkg::BANK_READ,
               sdbcs_pkg::BANK_WRITE: begin
                  if (sel && rw_cmd) begin
                     cnt_q <= t_blen;                            // RULE_06
                     if (cmd == sdbcs_pkg::CMD_READ) begin
                        st_q <= auto_precharge_bit ?
                                sdbcs_pkg::BANK_READ_AP :
                                sdbcs_pkg::BANK_READ;            // RULE_23
                     end else begin
                        st_q <= auto_precharge_bit ?
                                sdbcs_pkg::BANK_WRITE_AP :
                                sdbcs_pkg::BANK_WRITE;           // RULE_21
                     end
                  end else if (pre_me) begin
                     // Also cuts a plain burst short     RULE_08 RULE_09
                     st_q  <= sdbcs_pkg::BANK_PRECHARGING;       // RULE_07
                     cnt_q <= t_rp;
                  end else if (st_q != sdbcs_pkg::BANK_ACTIVE &&
                               (bst_me || other_rw || done)) begin
                     st_q <= sdbcs_pkg::BANK_ACTIVE;     // RULE_10 RULE_20
                  end
               end
               sdbcs_pkg::BANK_READ_AP, sdbcs_pkg::BANK_WRITE_AP: begin
                  // Interrupted or finished burst precharges itself
                  if (done || other_rw || bst_me) begin
                     st_q  <= sdbcs_pkg::BANK_PRECHARGING; // RULE_14 RULE_25
                     cnt_q <= t_rp;
                  end
               end
               sdbcs_pkg::BANK_PRECHARGING: begin
                  if (done) begin
                     st_q <= sdbcs_pkg::BANK_IDLE;               // RULE_12
                  end
               end
               default: begin
                  st_q <= sdbcs_pkg::BANK_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Device-wide state
   // ----------------------------------------------------------------
   logic [15:0] dev_cnt_q;
   logic        banks_idle;

   assign banks_idle = &all_idle;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_q     <= sdbcs_pkg::DEV_NORMAL;
         dev_cnt_q <= 16'h0000;
      end else begin
         if (dev_cnt_q != 16'h0000) begin
            dev_cnt_q <= dev_cnt_q - 16'h0001;
         end
         unique case (dev_q)
            sdbcs_pkg::DEV_NORMAL: begin
               if (cke_prev_q && !clock_enable && banks_idle &&
                   cmd == sdbcs_pkg::CMD_REF) begin
                  dev_q <= sdbcs_pkg::DEV_SELF;
               end else if (decode_ok && banks_idle &&
                            cmd == sdbcs_pkg::CMD_REF) begin
                  dev_q     <= sdbcs_pkg::DEV_REFRESH;           // RULE_16
                  dev_cnt_q <= t_rfc;
               end else if (decode_ok && banks_idle &&
                            cmd == sdbcs_pkg::CMD_LMR) begin
                  dev_q     <= sdbcs_pkg::DEV_MODE;              // RULE_16
                  dev_cnt_q <= {8'h00, t_mrd};
               end else if (pre_all) begin
                  dev_q     <= sdbcs_pkg::DEV_PRE_ALL;
                  dev_cnt_q <= {8'h00, t_rp};
               end
            end
            sdbcs_pkg::DEV_SELF: begin
               if (clock_enable) begin
                  dev_q     <= sdbcs_pkg::DEV_SR_EXIT;           // RULE_11
                  dev_cnt_q <= t_xsr;
               end
            end
            sdbcs_pkg::DEV_REFRESH, sdbcs_pkg::DEV_MODE,
            sdbcs_pkg::DEV_PRE_ALL, sdbcs_pkg::DEV_SR_EXIT: begin
               if (dev_cnt_q <= 16'h0001) begin
                  dev_q <= sdbcs_pkg::DEV_NORMAL;
               end
            end
            default: begin
               dev_q <= sdbcs_pkg::DEV_NORMAL;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Illegal command detection
   // ----------------------------------------------------------------
   logic [3:0] tgt;
   logic       ill;

   always_comb begin
      tgt = st_w[bank_w];
      ill = 1'b0;
      if (cke_prev_q && clock_enable && exec_cmd) begin
         if (dev_q != sdbcs_pkg::DEV_NORMAL) begin
            ill = 1'b1;
         end else begin
            unique case (cmd)
               sdbcs_pkg::CMD_ACT:
                  ill = (tgt != sdbcs_pkg::BANK_IDLE);
               sdbcs_pkg::CMD_READ, sdbcs_pkg::CMD_WRITE:
                  ill = (tgt != sdbcs_pkg::BANK_ACTIVE) &&
                        (tgt != sdbcs_pkg::BANK_READ) &&
                        (tgt != sdbcs_pkg::BANK_WRITE);
               sdbcs_pkg::CMD_PRE:
                  ill = !auto_precharge_bit &&
                        (tgt == sdbcs_pkg::BANK_ACTIVATING ||
                         tgt == sdbcs_pkg::BANK_PRECHARGING ||
                         tgt == sdbcs_pkg::BANK_READ_AP ||
                         tgt == sdbcs_pkg::BANK_WRITE_AP);
               sdbcs_pkg::CMD_BST:
                  ill = (st_w[last_bank_q] != sdbcs_pkg::BANK_READ) &&
                        (st_w[last_bank_q] != sdbcs_pkg::BANK_WRITE);
               sdbcs_pkg::CMD_REF, sdbcs_pkg::CMD_LMR:
                  ill = !banks_idle;
               default:
                  ill = 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic              aw_got_q;
   logic              w_got_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              do_wr;
   logic              err_q;
   logic              err_clr;
   logic [31:0]       status_w;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_W'(`SDBCS_OFS_CTRL))    ||
             (a == ADDR_W'(`SDBCS_OFS_TIMING0)) ||
             (a == ADDR_W'(`SDBCS_OFS_TIMING1)) ||
             (a == ADDR_W'(`SDBCS_OFS_STATUS))  ||
             (a == ADDR_W'(`SDBCS_OFS_ERROR));
   endfunction

   assign do_wr   = aw_got_q && w_got_q && !bvalid;
   assign err_clr = do_wr && wstrb_q[0] &&
                    (waddr_q == ADDR_W'(`SDBCS_OFS_ERROR)) &&
                    wdata_q[`SDBCS_ERR_ILL_BIT];
   assign status_w = {9'h000, cke_prev_q, last_bank_q, 1'b0, dev_q,
                      st_w[3], st_w[2], st_w[1], st_w[0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready  <= 1'b1;
         aw_got_q <= 1'b0;
         waddr_q  <= '0;
      end else if (do_wr) begin
         aw_got_q <= 1'b0;
      end else if (awvalid && awready) begin
         aw_got_q <= 1'b1;
         awready  <= 1'b0;
         waddr_q  <= awaddr;
      end else if (bvalid && bready) begin
         awready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b1;
         w_got_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (do_wr) begin
         w_got_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_got_q <= 1'b1;
         wready  <= 1'b0;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (bvalid && bready) begin
         wready  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `SDBCS_RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp  <= mapped(waddr_q) ? `SDBCS_RESP_OKAY : `SDBCS_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_en_q <= `SDBCS_CTRL_RESET;
         timing0_q <= {8'(`SDBCS_BLEN_RESET), 8'(`SDBCS_CYC(`SDBCS_MODE_LOAD_TIME_NS)),
                       8'(`SDBCS_CYC(`SDBCS_ACTIVATE_TO_ACCESS_TIME_NS)),
                       8'(`SDBCS_CYC(`SDBCS_TRP_NS))};
         timing1_q <= {16'(`SDBCS_CYC(`SDBCS_SELF_REFRESH_EXIT_TIME_NS)),
                       16'(`SDBCS_CYC(`SDBCS_REFRESH_CYCLE_TIME_NS))};
      end else if (do_wr) begin
         if (waddr_q == ADDR_W'(`SDBCS_OFS_CTRL) && wstrb_q[0]) begin
            ctrl_en_q <= wdata_q[`SDBCS_CTRL_EN_BIT];
         end
         if (waddr_q == ADDR_W'(`SDBCS_OFS_TIMING0)) begin
            timing0_q <= merge(timing0_q, wdata_q, wstrb_q);
         end
         if (waddr_q == ADDR_W'(`SDBCS_OFS_TIMING1)) begin
            timing1_q <= merge(timing1_q, wdata_q, wstrb_q);
         end
      end
   end

   // Detection wins over a same-cycle software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_q <= 1'b0;
      end else begin
         err_q <= ill || (err_q && !err_clr);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `SDBCS_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= mapped(araddr) ? `SDBCS_RESP_OKAY : `SDBCS_RESP_SLVERR;
         unique case (araddr)
            ADDR_W'(`SDBCS_OFS_CTRL):    rdata <= {31'h0, ctrl_en_q};
            ADDR_W'(`SDBCS_OFS_TIMING0): rdata <= timing0_q;
            ADDR_W'(`SDBCS_OFS_TIMING1): rdata <= timing1_q;
            ADDR_W'(`SDBCS_OFS_STATUS):  rdata <= status_w;
            ADDR_W'(`SDBCS_OFS_ERROR):   rdata <= {31'h0, err_q};
            default:                     rdata <= 32'h00000000;
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bank_state      = status_w[15:0];
   assign device_state    = dev_q;
   assign illegal_command = err_q;

endmodule
